// ### logic/eep_slave.sv
// Serial-bus slave of a 256-byte EEPROM with a 16-byte page buffer.
// Assumes a bus master on eep_if and a supervisor reset on clk_i.
//
// Function
// RQ1 - START/STOP are SDA edges while SCL high
// RQ2 - Supervisor reset aborts traffic, programming finishes
// RQ3 - Address byte upper nibble is type 1010
// RQ4 - Address LSB one reads, zero writes
// RQ5 - Acknowledge only a matching slave address
// RQ6 - Acknowledge holds SDA low on ninth clock
// RQ7 - Acknowledge word address and every data byte
// RQ8 - Read: send byte, next on ack, else stop
// RQ9 - Byte write: address, word, data, STOP
// RQ10 - STOP starts programming; ignore bus while busy
// RQ11 - Page write carries up to sixteen bytes
// RQ12 - Data writes increment only page offset
// RQ13 - Offset is bits 3:0, page bits 7:4
// RQ14 - Over sixteen bytes wrap and overwrite
// RQ15 - Polling: no ack while busy
// RQ16 - Write protect refuses first data byte
// RQ17 - Pointer holds last location plus one
// RQ18 - Read pointer wraps 255 to zero
// RQ19 - Current read: ack, one byte, nack, STOP
// RQ20 - Random read uses dummy write first
// RQ21 - Sequential reads increment whole pointer
`timescale 1ns/1ps
module eep_slave
  import eep_pkg::*;
#(
  parameter int unsigned PROG_CYC_P = eep_pkg::PROG_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial bus
  eep_if.slave bus,
  // Device controls
  input wire logic wp_i,
  input wire logic sup_rst_i,
  // Status
  output logic busy_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int unsigned CW = $clog2(PROG_CYC_P + 1);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DEV = 6'h02,
    S_WORD = 6'h04,
    S_WDATA = 6'h08,
    S_RDATA = 6'h10,
    S_RACK = 6'h20
  } eep_sst_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] wp_s;
    logic scl_p;
    logic sda_p;
    eep_sst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ackph;
    logic ack;
    logic tx;
    logic rd;
    logic nack;
    logic [7:0] ptr;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] pval;
    logic pend;
    logic busy;
    logic [CW-1:0] pcnt;
  } eep_slv_t;

  // SCL and SDA synchronisers and edge history start at the idle bus level, so no false edge follows reset
  localparam eep_slv_t RST_Q = '{st: S_IDLE, ptr: PTR_RST, scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1,
    default: '0};

  eep_slv_t q;
  eep_slv_t d;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] mem_rd;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic commit;

  assign scl = q.scl_s[1];
  assign sda = q.sda_s[1];
  assign rise = scl && !q.scl_p;
  assign fall = !scl && q.scl_p;
  assign start = scl && q.scl_p && q.sda_p && !sda; // RQ1
  assign stop = scl && q.scl_p && !q.sda_p && sda; // RQ1
  assign mem_rd = mem[q.ptr];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    commit = 1'b0;
    d.scl_s = {q.scl_s[0], bus.scl};
    d.sda_s = {q.sda_s[0], bus.sda};
    d.wp_s = {q.wp_s[0], wp_i};
    d.scl_p = scl;
    d.sda_p = sda;
    // Program cycle runs on regardless of bus or supervisor reset
    if (q.busy)
    begin
      if (q.pcnt == CW'(PROG_CYC_P - 1))
      begin
        d.busy = 1'b0;
        d.pcnt = '0;
        commit = 1'b1; // RQ11
      end
      else
      begin
        d.pcnt = q.pcnt + CW'(1);
      end
    end
    if (sup_rst_i)
    begin
      d.st = S_IDLE; // RQ2
      d.ack = 1'b0;
      d.ackph = 1'b0;
      d.tx = 1'b0;
      d.pend = 1'b0;
    end
    else if (start)
    begin
      d.st = S_DEV;
      d.cnt = '0;
      d.ackph = 1'b0;
      d.ack = 1'b0;
      d.tx = 1'b0;
    end
    else if (stop)
    begin
      if (q.pend)
      begin
        d.busy = 1'b1; // RQ10
        d.pcnt = '0;
      end
      d.pend = 1'b0;
      d.st = S_IDLE;
      d.ack = 1'b0;
      d.ackph = 1'b0;
      d.tx = 1'b0;
    end
    else
    begin
      unique case (q.st)
        S_IDLE:
        begin
          d.st = S_IDLE; // RQ1
        end
        S_DEV, S_WORD, S_WDATA:
        begin
          if (rise && !q.ackph)
          begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = q.cnt + 4'h1;
          end
          if (fall && q.ackph)
          begin
            // Ninth clock over: release SDA
            d.ackph = 1'b0;
            d.ack = 1'b0;
            d.cnt = '0;
            if (q.st == S_DEV && q.rd)
            begin
              d.st = S_RDATA;
              d.sh = mem_rd; // RQ17
              d.tx = 1'b1;
            end
            else if (q.st == S_DEV)
            begin
              d.st = S_WORD;
            end
            else
            begin
              d.st = S_WDATA;
            end
          end
          else if (fall && q.cnt == BIT_ACK)
          begin
            d.ackph = 1'b1;
            d.ack = 1'b1; // RQ6 RQ7
            if (q.st == S_DEV)
            begin
              if (q.sh[7:4] != DEV_TYPE || q.busy) // RQ3 RQ5 RQ10 RQ15
              begin
                d.ack = 1'b0;
                d.ackph = 1'b0;
                d.st = S_IDLE;
              end
              else
              begin
                d.rd = q.sh[0]; // RQ4
              end
            end
            else if (q.st == S_WORD)
            begin
              d.ptr = q.sh; // RQ9 RQ20
              d.pval = '0;
            end
            else if (q.wp_s[1])
            begin
              // Protected: refuse data and never arm programming
              d.ack = 1'b0; // RQ16
              d.ackph = 1'b0;
              d.st = S_IDLE;
            end
            else
            begin
              d.pbuf[q.ptr[PAGE_W-1:0]] = q.sh; // RQ14
              d.pval[q.ptr[PAGE_W-1:0]] = 1'b1;
              d.ptr[PAGE_W-1:0] = q.ptr[PAGE_W-1:0] + 4'h1; // RQ12 RQ13
              d.pend = 1'b1;
            end
          end
        end
        S_RDATA:
        begin
          if (rise)
          begin
            d.cnt = q.cnt + 4'h1;
          end
          if (fall && q.cnt == BIT_ACK)
          begin
            d.tx = 1'b0; // RQ8
            d.ptr = q.ptr + 8'h01; // RQ18 RQ21
            d.st = S_RACK;
          end
          else if (fall)
          begin
            d.sh = {q.sh[6:0], 1'b0};
          end
        end
        S_RACK:
        begin
          if (rise)
          begin
            d.nack = sda;
          end
          if (fall && !q.nack)
          begin
            d.st = S_RDATA; // RQ8 RQ21
            d.sh = mem_rd;
            d.tx = 1'b1;
            d.cnt = '0;
          end
          else if (fall)
          begin
            d.st = S_IDLE; // RQ8 RQ19
          end
        end
        default:
        begin
          d.st = S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers and array
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= RST_Q;
    end
    else
    begin
      q <= d;
    end
  end

  // Whole page lands in one cycle; untouched offsets keep old data
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < MEM_BYTES; i++)
      begin
        mem[i] <= ERASED;
      end
    end
    else if (commit)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (q.pval[i])
        begin
          mem[{q.ptr[7:PAGE_W], 4'(i)}] <= q.pbuf[i]; // RQ11 RQ13
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_n = !(q.ack || (q.tx && !q.sh[7])); // RQ6 RQ8
  assign busy_o = q.busy;

endmodule : eep_slave

// ### include/eep_pkg.sv
// Shared constants for the serial EEPROM slave and its bus master.
// Assumes a 100 MHz system clock on both ends.
package eep_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned T_PROG_US = 5000;
  localparam int unsigned PROG_CYC = T_PROG_US * CLK_MHZ;
  // Quarter of a 400 kHz bus clock period, least time, rounded up
  localparam int unsigned T_QTR_NS = 625;
  localparam int unsigned QTR_CYC = (T_QTR_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Array and address layout
  // ----------------------------------------
  localparam int unsigned MEM_BYTES = 256;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_W = 4;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] ERASED = 8'hff;

  // ----------------------------------------
  // Master primitive operations
  // ----------------------------------------
  typedef enum logic [1:0] {
    EEP_OP_START = 2'h0,
    EEP_OP_STOP = 2'h1,
    EEP_OP_WRITE = 2'h2,
    EEP_OP_READ = 2'h3
  } eep_op_t;

endpackage : eep_pkg

// ### include/eep_if.sv
// Two-wire bus joining the EEPROM slave and the bus master.
// SDA is open drain with a pull-up; SCL is driven by the master alone.
`timescale 1ns/1ps
interface eep_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic sda;

  // Wired-AND with pull-up
  assign sda = !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe_n);
endinterface : eep_if

// ### logic/eep_master.sv
// Bus master for the EEPROM slave: one primitive per request.
// Assumes an open-drain SDA resolved in eep_if; SCL made here by a divider.
`timescale 1ns/1ps
module eep_master
  import eep_pkg::*;
#(
  parameter int unsigned QTR_CYC_P = eep_pkg::QTR_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial bus
  eep_if.master bus,
  // Request
  input wire logic op_valid_i,
  output logic op_ready_o,
  input wire eep_pkg::eep_op_t op_code_i,
  input wire logic [7:0] op_data_i,
  input wire logic op_ack_i,
  // Answer
  output logic done_o,
  output logic [7:0] rd_data_o,
  output logic ack_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int unsigned QW = $clog2(QTR_CYC_P + 1);

  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_START = 4'h2,
    M_STOP = 4'h4,
    M_BYTE = 4'h8
  } eep_mst_t;

  typedef struct packed {
    eep_mst_t st;
    logic [1:0] ph;
    logic [QW-1:0] qc;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd;
    logic ackin;
    logic scl;
    logic sda;
    logic [1:0] sda_s;
    logic done;
    logic ack;
    logic [7:0] rdata;
  } eep_mstr_t;

  localparam eep_mstr_t RST_Q = '{st: M_IDLE, scl: 1'b1, sda: 1'b1, sda_s: 2'h3, default: '0};

  eep_mstr_t q;
  eep_mstr_t d;
  logic tick;

  assign tick = q.qc == QW'(QTR_CYC_P - 1);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.sda_s = {q.sda_s[0], bus.sda};
    d.done = 1'b0;
    if (q.st == M_IDLE)
    begin
      if (op_valid_i)
      begin
        d.ph = '0;
        d.qc = '0;
        d.bitn = '0;
        d.sh = op_data_i;
        d.rd = op_code_i == EEP_OP_READ; // RQ4
        d.ackin = op_ack_i;
        unique case (op_code_i)
          EEP_OP_START: d.st = M_START;
          EEP_OP_STOP: d.st = M_STOP;
          EEP_OP_WRITE, EEP_OP_READ: d.st = M_BYTE;
        endcase
      end
    end
    else if (!tick)
    begin
      d.qc = q.qc + QW'(1);
    end
    else
    begin
      d.qc = '0;
      d.ph = q.ph + 2'h1;
      if (q.st == M_BYTE && q.ph == 2'h2)
      begin
        // Sample at the end of SCL high
        if (q.bitn == BIT_ACK)
        begin
          d.ack = !q.sda_s[1]; // RQ6
        end
        else if (q.rd)
        begin
          d.sh = {q.sh[6:0], q.sda_s[1]};
        end
      end
      if (q.ph == 2'h3)
      begin
        if (q.st == M_BYTE)
        begin
          if (!q.rd)
          begin
            d.sh = {q.sh[6:0], 1'b0};
          end
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == BIT_ACK)
          begin
            d.st = M_IDLE;
            d.done = 1'b1;
            d.rdata = q.sh;
          end
        end
        else
        begin
          d.st = M_IDLE;
          d.done = 1'b1;
        end
      end
    end
    // Line levels follow the next phase
    unique case (d.st)
      M_IDLE:
      begin
        d.scl = q.scl;
        d.sda = q.sda;
      end
      M_START:
      begin
        d.scl = d.ph == 2'h1 || d.ph == 2'h2;
        d.sda = d.ph < 2'h2; // RQ1
      end
      M_STOP:
      begin
        d.scl = d.ph != 2'h0;
        d.sda = d.ph >= 2'h2; // RQ1
      end
      M_BYTE:
      begin
        d.scl = d.ph == 2'h1 || d.ph == 2'h2;
        if (d.bitn == BIT_ACK)
        begin
          d.sda = d.rd ? !d.ackin : 1'b1; // RQ6 RQ19
        end
        else
        begin
          d.sda = d.rd ? 1'b1 : d.sh[7];
        end
      end
      default:
      begin
        d.scl = 1'b1;
        d.sda = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= RST_Q;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign op_ready_o = q.st == M_IDLE;
  assign done_o = q.done;
  assign rd_data_o = q.rdata;
  assign ack_o = q.ack;
  assign bus.scl = q.scl;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_n = q.sda;

endmodule : eep_master

// ### test/eep_props.sv
// Bus checker for the EEPROM slave and its master.
// Assumes the bench wires it to the shared bus interface signals.
`timescale 1ns/1ps
module eep_props #(
  parameter int unsigned QTR_CYC_P = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus signals
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n
);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic scl_q;
  logic sda_q;
  logic act_q;
  logic dir_q;
  logic [11:0] bit_q;
  logic [11:0] drv_q;
  logic [3:0] lo_q;
  logic [3:0] pos;
  assign pos = 4'(bit_q % 12'd9);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      act_q <= 1'b0;
      dir_q <= 1'b0;
      bit_q <= '0;
      drv_q <= '0;
      lo_q <= '0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
      begin
        act_q <= 1'b1;
        bit_q <= '0;
      end
      else if (scl && scl_q && !sda_q && sda)
        act_q <= 1'b0;
      else if (scl && !scl_q)
        bit_q <= bit_q + 12'd1;
      if (scl && !scl_q && bit_q == 12'd7)
        dir_q <= sda;
      lo_q <= scl ? 4'd0 : (lo_q == 4'd15 ? lo_q : lo_q + 4'd1);
      drv_q <= s_sda_oe_n ? 12'd0 : drv_q + 12'd1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_IDLE_RELEASED: assert property (!act_q |-> s_sda_oe_n)
    else $error("slave drives SDA outside a frame");
  AST_STABLE_SCL_HIGH: assert property (scl && scl_q |-> $stable(s_sda_oe_n))
    else $error("slave moved SDA while SCL high");
  // Bit count settles one cycle after each SCL rise, so slot checks need SCL high twice
  AST_ADDR_SILENT: assert property (act_q && scl && scl_q && bit_q >= 12'd1 && bit_q <= 12'd8 |-> s_sda_oe_n)
    else $error("slave drove SDA during address byte");
  AST_CHANGE_AFTER_FALL: assert property ($changed(s_sda_oe_n) |-> !scl && lo_q <= 4'd6)
    else $error("slave SDA change not just after SCL fall");
  AST_ACK_ONE_PERIOD: assert property ($rose(s_sda_oe_n) && !dir_q |->
    drv_q >= 12'(4 * QTR_CYC_P - 3) && drv_q <= 12'(4 * QTR_CYC_P + 3))
    else $error("write acknowledge length wrong");
  AST_WR_DATA_SILENT: assert property (act_q && !dir_q && scl && scl_q && pos != 4'd0 |-> s_sda_oe_n)
    else $error("slave drove SDA on a write data bit");
  AST_RD_RELEASE_NINTH: assert property (act_q && dir_q && scl && scl_q && bit_q > 12'd9 && pos == 4'd0 |->
    s_sda_oe_n)
    else $error("slave held SDA in read acknowledge slot");
  AST_MST_FREE_ACK: assert property (act_q && !dir_q && scl && scl_q && bit_q > 12'd0 && pos == 4'd0 |->
    m_sda_oe_n)
    else $error("master held SDA in write acknowledge slot");
  AST_MST_FREE_READ: assert property (act_q && dir_q && scl && scl_q && bit_q > 12'd9 && pos > 4'd1 |->
    m_sda_oe_n)
    else $error("master drove SDA during read data");
endmodule : eep_props

// ### test/eep_tb.sv
// Bench joining the EEPROM slave and master on one bus.
// Assumes package, interface, design and checker are compiled first.
`timescale 1ns/1ps
module eep_tb;
  import eep_pkg::*;
  localparam int unsigned Q = 8;
  logic clk_i;
  logic rst_i;
  logic op_valid_i;
  logic op_ready_o;
  eep_op_t op_code_i;
  logic [7:0] op_data_i;
  logic op_ack_i;
  logic done_o;
  logic [7:0] rd_data_o;
  logic ack_o;
  logic wp_i;
  logic sup_rst_i;
  logic busy_o;
  logic [7:0] mem [256];
  int failures;
  int num_checks;

  eep_if bus ();
  // Program cycle outlasts a whole polling frame, so busy refusals are seen
  eep_slave #(.PROG_CYC_P(600)) i_eep_slave (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .wp_i(wp_i),
    .sup_rst_i(sup_rst_i), .busy_o(busy_o));
  eep_master #(.QTR_CYC_P(Q)) i_eep_master (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .op_valid_i(op_valid_i),
    .op_ready_o(op_ready_o), .op_code_i(op_code_i), .op_data_i(op_data_i), .op_ack_i(op_ack_i),
    .done_o(done_o), .rd_data_o(rd_data_o), .ack_o(ack_o));
  eep_props #(.QTR_CYC_P(Q)) i_eep_props (.clk_i(clk_i), .rst_i(rst_i), .scl(bus.scl), .sda(bus.sda),
    .m_sda_oe_n(bus.m_sda_oe_n), .s_sda_oe_n(bus.s_sda_oe_n));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Bounded wait on done or on busy; running out ends the run
  task automatic wait_for(input bit on_busy);
    int n;
    n = 0;
    while ((on_busy ? busy_o !== 1'b0 : done_o !== 1'b1) && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000)
    begin
      failures++;
      test_done();
    end
  endtask : wait_for

  task automatic op(input eep_op_t c, input logic [7:0] d, input logic a);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_data_i <= d;
    op_ack_i <= a;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    wait_for(1'b0);
    check("ready", {7'h0, op_ready_o}, 8'h01);
  endtask : op

  task automatic wb(input logic [7:0] d, input logic e);
    op(EEP_OP_WRITE, d, 1'b0);
    check("ack", {7'h0, ack_o}, {7'h0, e});
  endtask : wb

  task automatic adr(input logic [7:0] d, input logic e);
    op(EEP_OP_START, 8'h00, 1'b0);
    wb(d, e);
  endtask : adr

  task automatic stop();
    op(EEP_OP_STOP, 8'h00, 1'b0);
  endtask : stop

  task automatic wr(input logic [7:0] a, input int cnt, input logic [7:0] d0);
    adr(8'ha0, 1'b1);
    wb(a, 1'b1);
    for (int k = 0; k < cnt; k++)
    begin
      wb(d0 + 8'(k), !wp_i);
      if (!wp_i)
        mem[{a[7:4], a[3:0] + 4'(k)}] = d0 + 8'(k);
    end
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] a, input int cnt);
    adr(8'ha0, 1'b1);
    wb(a, 1'b1);
    adr(8'ha1, 1'b1);
    for (int k = 0; k < cnt; k++)
    begin
      op(EEP_OP_READ, 8'h00, k < cnt - 1);
      check("data", rd_data_o, mem[8'(a + 8'(k))]);
    end
    stop();
  endtask : rd

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    failures = 0;
    num_checks = 0;
    foreach (mem[i]) mem[i] = 8'hff;
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_code_i = EEP_OP_START;
    op_data_i = 8'h00;
    op_ack_i = 1'b0;
    wp_i = 1'b0;
    sup_rst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    adr(8'h50, 1'b0);
    stop();
    adr(8'hb0, 1'b0);
    stop();
    wr(8'h10, 1, 8'h5a);
    adr(8'ha0, 1'b0);
    stop();
    check("busy", {7'h0, busy_o}, 8'h01);
    wait_for(1'b1);
    adr(8'ha0, 1'b1);
    stop();
    rd(8'h10, 1);
    adr(8'ha1, 1'b1);
    op(EEP_OP_READ, 8'h00, 1'b0);
    check("data", rd_data_o, mem[8'h11]);
    stop();
    wr(8'h2e, 18, 8'h80);
    wait_for(1'b1);
    rd(8'h20, 16);
    wr(8'h00, 1, 8'h3c);
    wait_for(1'b1);
    rd(8'hff, 2);
    wp_i <= 1'b1;
    wr(8'h30, 1, 8'h77);
    check("busy", {7'h0, busy_o}, 8'h00);
    wp_i <= 1'b0;
    rd(8'h30, 1);
    adr(8'ha0, 1'b1);
    wb(8'h60, 1'b1);
    sup_rst_i <= 1'b1;
    wb(8'h99, 1'b0);
    stop();
    sup_rst_i <= 1'b0;
    wr(8'h50, 1, 8'h11);
    sup_rst_i <= 1'b1;
    adr(8'ha0, 1'b0);
    stop();
    check("busy", {7'h0, busy_o}, 8'h01);
    wait_for(1'b1);
    sup_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h60, 1);
    rd(8'h50, 1);
    test_done();
  end
endmodule : eep_tb
